//--- hw/arp_pkg.sv
// Constants and carrier types for the result output port block.
// Assumes one 125 MHz core clock and pins that are already synchronous.
package arp_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RES_W         = 16;
    localparam int BUS_AW        = 8;
    localparam int BUS_DW        = 32;
    localparam int BIT_CNT_W     = 4;
    localparam int SCLK_CNT_W    = 5;

    localparam logic [BUS_AW-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [BUS_AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [BUS_AW-1:0] ADDR_RESULT = 8'h08;

    localparam int   CTRL_DRIVE_BIT = 0;
    localparam logic CTRL_DRIVE_RST = 1'b1;
    localparam int   ST_SERIAL_BIT  = 0;
    localparam int   ST_EXT_BIT     = 1;
    localparam int   ST_RDC_BIT     = 2;
    localparam int   ST_DIV_LSB     = 3;
    localparam int   ST_SHIFT_BIT   = 5;

    // Pins that the serial port borrows from the data bus
    localparam int PIN_D0     = 0;
    localparam int PIN_D1     = 1;
    localparam int PIN_DIV0   = 2;
    localparam int PIN_DIV1   = 3;
    localparam int PIN_CLKSRC = 4;
    localparam int PIN_RDC    = 7;
    localparam int PIN_SERIAL_RESULT_OUT  = 8;
    localparam int PIN_SCLK   = 9;
    localparam int BYTE_W     = 8;

    // Least internal serial clock period per divide code
    localparam int SCLK_NS_0 = 25;
    localparam int SCLK_NS_1 = 50;
    localparam int SCLK_NS_2 = 100;
    localparam int SCLK_NS_3 = 200;
    localparam int SCLK_CYC_0 = (SCLK_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_CYC_1 = (SCLK_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_CYC_2 = (SCLK_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_CYC_3 = (SCLK_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [BUS_DW-1:0] wdata;
        logic              wr;
        logic              rd;
    } arp_bus_req_t;

    typedef struct packed {
        logic             valid;
        logic [RES_W-1:0] data;
    } arp_result_t;

    typedef struct packed {
        logic [RES_W-1:0] dout;
        logic [RES_W-1:0] oe_n;
    } arp_pins_t;

    typedef enum logic [1:0] {SH_IDLE, SH_INT, SH_EXT} arp_shift_state_t;

    typedef struct packed {
        logic                  drive;
        logic [RES_W-1:0]      raw;
        arp_shift_state_t      sh;
        logic [RES_W-1:0]      word;
        logic [BIT_CNT_W-1:0]  bits;
        logic [SCLK_CNT_W-1:0] per;
        logic [SCLK_CNT_W-1:0] cnt;
        logic                  sclk;
        logic                  ext_q;
        arp_pins_t             pins;
        logic [BUS_DW-1:0]     rdata;
    } arp_state_t;
endpackage : arp_pkg

//--- hw/arp_port.sv
// Result output port: parallel or serial delivery of conversion words.
// Assumes select inputs and pins are synchronous to core_clk and static
// while a result is in flight; the pad ring resolves the enables.
// Operation
// - Half select low: low byte on lines 7..0, high byte on 15..8.
// - Half select high: low byte on lines 15..8, high byte on 7..0.
// - Coding select high: result delivered as straight binary.
// - Coding select low: top bit inverted, giving twos complement.
// - Port type low: every data line drives a result bit.
// - Port type high: serial mode, some data lines become serial pins.
// - Serial mode: lines 0 and 1 stay high impedance.
// - Parallel mode: divide lines drive result bits 2 and 3.
// - Parallel mode: clock source line drives result bit 4.
// - Divide lines are inputs only in serial read-after-convert, internal clock.
// - Other serial modes: divide lines held high impedance.
// - Serial, internal clock: device makes and drives the serial clock.
// - Serial, external clock: host clocks, data follows its edges.
// - Read timing high shifts during conversion with the internal clock, low after it; the external clock always shifts after it.
// - Divide code sets least clock period 25/50/100/200 ns.
`timescale 1ns/1ps
module arp_port (
    input  logic                           core_clk,             // Core clock
    input  logic                           arst_n,               // Async reset
    input  arp_pkg::arp_bus_req_t          bus_req,              // Register request
    output logic [arp_pkg::BUS_DW-1:0]     bus_rdata,            // Read data
    input  arp_pkg::arp_result_t           res_in,               // New result
    input  logic                           conv_start,           // Conversion begins
    input  logic                           half_order_select,    // Byte order
    input  logic                           output_coding_select, // Binary or twos
    input  logic                           port_type_select,     // Serial when high
    input  logic [arp_pkg::RES_W-1:0]      d_in,                 // Pin levels
    output logic [arp_pkg::RES_W-1:0]      d_out,                // Pin drive
    output logic [arp_pkg::RES_W-1:0]      d_oe_n,               // Pin enable, low drives
    output logic                           shift_active          // Serial word in flight
);

    function automatic logic [arp_pkg::RES_W-1:0] arp_fmt(
        input logic [arp_pkg::RES_W-1:0] w,
        input logic                      binary
    );
        arp_fmt = binary ? w : {~w[arp_pkg::RES_W-1], w[arp_pkg::RES_W-2:0]};
    endfunction : arp_fmt

    function automatic logic [arp_pkg::RES_W-1:0] arp_place(
        input logic [arp_pkg::RES_W-1:0] w,
        input logic                      swap
    );
        arp_place = swap ? {w[arp_pkg::BYTE_W-1:0], w[arp_pkg::RES_W-1:arp_pkg::BYTE_W]}
                         : w;
    endfunction : arp_place

    function automatic logic [arp_pkg::SCLK_CNT_W-1:0] arp_period(
        input logic [1:0] code
    );
        case (code)
            2'h0:    arp_period = arp_pkg::SCLK_CNT_W'(arp_pkg::SCLK_CYC_0);
            2'h1:    arp_period = arp_pkg::SCLK_CNT_W'(arp_pkg::SCLK_CYC_1);
            2'h2:    arp_period = arp_pkg::SCLK_CNT_W'(arp_pkg::SCLK_CYC_2);
            default: arp_period = arp_pkg::SCLK_CNT_W'(arp_pkg::SCLK_CYC_3);
        endcase
    endfunction : arp_period

    arp_pkg::arp_state_t st_reg;
    arp_pkg::arp_state_t st_next;

    logic                       ser_ext;
    logic                       ser_rdc;
    logic                       ser_rac;
    logic [1:0]                 div_code;
    logic [arp_pkg::RES_W-1:0]  fmt_now;

    // Serial selects live on borrowed data lines, read only in serial mode
    always_comb begin
        ser_ext  = port_type_select & d_in[arp_pkg::PIN_CLKSRC];
        // Line 7 selects read timing only with the internal clock
        ser_rdc  = port_type_select & ~ser_ext & d_in[arp_pkg::PIN_RDC];
        ser_rac  = port_type_select & ~ser_ext & ~ser_rdc;
        div_code = ser_rac ? {d_in[arp_pkg::PIN_DIV1], d_in[arp_pkg::PIN_DIV0]}
                           : 2'h0;
        fmt_now  = arp_fmt(st_reg.raw, output_coding_select);
    end

    always_comb begin
        st_next = st_reg;
        st_next.ext_q = d_in[arp_pkg::PIN_SCLK];
        if (res_in.valid) begin
            st_next.raw = res_in.data;
        end

        // Shift engine
        case (st_reg.sh)
            arp_pkg::SH_INT: begin
                if (st_reg.cnt == st_reg.per - 1'b1) begin
                    st_next.cnt = '0;
                    if (st_reg.bits == '0) begin
                        st_next.sh = arp_pkg::SH_IDLE;
                    end else begin
                        st_next.word = {st_reg.word[arp_pkg::RES_W-2:0], 1'b0};
                        st_next.bits = st_reg.bits - 1'b1;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                end
            end
            arp_pkg::SH_EXT: begin
                // Host rising edge advances the data
                if (d_in[arp_pkg::PIN_SCLK] && !st_reg.ext_q) begin
                    if (st_reg.bits == '0) begin
                        st_next.sh = arp_pkg::SH_IDLE;
                    end else begin
                        st_next.word = {st_reg.word[arp_pkg::RES_W-2:0], 1'b0};
                        st_next.bits = st_reg.bits - 1'b1;
                    end
                end
            end
            default: begin
                st_next.sh = arp_pkg::SH_IDLE;
            end
        endcase

        // A new start restarts the word; the selects are static by contract
        if (port_type_select && ((res_in.valid && !ser_rdc) || (conv_start && ser_rdc))) begin
            st_next.sh   = ser_ext ? arp_pkg::SH_EXT : arp_pkg::SH_INT;
            st_next.word = ser_rdc ? fmt_now
                                   : arp_fmt(res_in.data, output_coding_select);
            st_next.bits = arp_pkg::BIT_CNT_W'(arp_pkg::RES_W - 1);
            st_next.cnt  = '0;
            st_next.per  = arp_period(div_code);
        end
        st_next.sclk = (st_next.sh == arp_pkg::SH_INT) && (st_next.cnt >= (st_next.per >> 1));

        // Pin drive
        st_next.pins.dout = '0;
        st_next.pins.oe_n = '1;
        if (!port_type_select) begin
            if (st_reg.drive) begin
                // Lines 2..4 are plain result bits here
                st_next.pins.dout = arp_place(fmt_now, half_order_select);
                st_next.pins.oe_n = '0;
            end
        end else if (st_reg.drive) begin
            st_next.pins.dout[arp_pkg::PIN_SERIAL_RESULT_OUT] = st_next.word[arp_pkg::RES_W-1];
            st_next.pins.oe_n[arp_pkg::PIN_SERIAL_RESULT_OUT] = 1'b0;
            if (!ser_ext) begin
                st_next.pins.dout[arp_pkg::PIN_SCLK] = st_next.sclk;
                st_next.pins.oe_n[arp_pkg::PIN_SCLK] = 1'b0;
            end
        end

        // Register slave
        st_next.rdata = '0;
        if (bus_req.wr && bus_req.addr == arp_pkg::ADDR_CTRL) begin
            st_next.drive = bus_req.wdata[arp_pkg::CTRL_DRIVE_BIT];
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                arp_pkg::ADDR_CTRL: begin
                    st_next.rdata[arp_pkg::CTRL_DRIVE_BIT] = st_reg.drive;
                end
                arp_pkg::ADDR_STATUS: begin
                    st_next.rdata[arp_pkg::ST_SERIAL_BIT] = port_type_select;
                    st_next.rdata[arp_pkg::ST_EXT_BIT]    = ser_ext;
                    st_next.rdata[arp_pkg::ST_RDC_BIT]    = ser_rdc;
                    st_next.rdata[arp_pkg::ST_DIV_LSB+:2] = div_code;
                    st_next.rdata[arp_pkg::ST_SHIFT_BIT]  = st_reg.sh != arp_pkg::SH_IDLE;
                end
                arp_pkg::ADDR_RESULT: begin
                    st_next.rdata[arp_pkg::RES_W-1:0] = fmt_now;
                end
                default: begin
                    st_next.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg           <= '0;
            st_reg.drive     <= arp_pkg::CTRL_DRIVE_RST;
            st_reg.sh        <= arp_pkg::SH_IDLE;
            st_reg.pins.oe_n <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata    = st_reg.rdata;
    assign d_out        = st_reg.pins.dout;
    assign d_oe_n       = st_reg.pins.oe_n;
    assign shift_active = st_reg.sh != arp_pkg::SH_IDLE;

    // Checking helpers
    logic [arp_pkg::RES_W-1:0]      fmt_q;
    logic [arp_pkg::RES_W-1:0]      raw_q;
    logic                           sclk_q;
    logic [arp_pkg::SCLK_CNT_W-1:0] gap_cnt;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fmt_q   <= '0;
            raw_q   <= '0;
            sclk_q  <= 1'b0;
            gap_cnt <= '1;
        end else begin
            fmt_q  <= fmt_now;
            raw_q  <= st_reg.raw;
            sclk_q <= st_reg.sclk;
            if (st_reg.sh == arp_pkg::SH_IDLE) begin
                gap_cnt <= '1;
            end else if (st_reg.sclk && !sclk_q) begin
                gap_cnt <= arp_pkg::SCLK_CNT_W'(1);
            end else if (gap_cnt != '1) begin
                gap_cnt <= gap_cnt + 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_par_setup(logic swap);
        !port_type_select && st_reg.drive && half_order_select == swap;
    endsequence

    property p_low_order;
        s_par_setup(1'b0) |=> d_out == fmt_q;
    endproperty
    a_low_order: assert property (p_low_order) else $error("byte order wrong, swap low");

    property p_high_order;
        s_par_setup(1'b1) |=>
            d_out == {fmt_q[arp_pkg::BYTE_W-1:0], fmt_q[arp_pkg::RES_W-1:arp_pkg::BYTE_W]};
    endproperty
    a_high_order: assert property (p_high_order) else $error("byte order wrong, swap high");

    property p_binary;
        s_par_setup(1'b0) and output_coding_select |=> d_out == raw_q;
    endproperty
    a_binary: assert property (p_binary) else $error("straight binary altered");

    property p_twos;
        s_par_setup(1'b0) and !output_coding_select |=>
            d_out == {~raw_q[arp_pkg::RES_W-1], raw_q[arp_pkg::RES_W-2:0]};
    endproperty
    a_twos: assert property (p_twos) else $error("top bit not inverted");

    property p_par_drive;
        !port_type_select && st_reg.drive |=> d_oe_n == '0;
    endproperty
    a_par_drive: assert property (p_par_drive) else $error("parallel line not driven");

    property p_ser_hiz;
        port_type_select |=> d_oe_n[arp_pkg::PIN_D0] && d_oe_n[arp_pkg::PIN_D1]
                             && d_oe_n[arp_pkg::PIN_DIV0] && d_oe_n[arp_pkg::PIN_DIV1];
    endproperty
    a_ser_hiz: assert property (p_ser_hiz) else $error("serial mode drove a freed line");

    property p_int_sclk;
        port_type_select && !ser_ext && st_reg.drive |=> !d_oe_n[arp_pkg::PIN_SCLK];
    endproperty
    a_int_sclk: assert property (p_int_sclk) else $error("internal clock not driven");

    property p_ext_sclk;
        port_type_select && ser_ext |=> d_oe_n[arp_pkg::PIN_SCLK];
    endproperty
    a_ext_sclk: assert property (p_ext_sclk) else $error("external clock pin driven");

    sequence s_rac_start;
        port_type_select && !ser_ext && !ser_rdc && res_in.valid;
    endsequence

    sequence s_rdc_start;
        port_type_select && !ser_ext && ser_rdc && conv_start;
    endsequence

    property p_read_timing;
        s_rac_start or s_rdc_start |=> st_reg.sh == arp_pkg::SH_INT && st_reg.bits == 4'hF;
    endproperty
    a_read_timing: assert property (p_read_timing) else $error("shift start missed");

    property p_div_code;
        s_rac_start |=> st_reg.per == arp_period($past(div_code));
    endproperty
    a_div_code: assert property (p_div_code) else $error("divide code not applied");

    property p_period;
        st_reg.sh == arp_pkg::SH_INT && st_reg.sclk && !sclk_q |-> gap_cnt >= st_reg.per;
    endproperty
    a_period: assert property (p_period) else $error("serial clock period too short");

endmodule : arp_port

//--- dv/arp_host_model.sv
// Host side of the result port: drives the serial select pins and an external clock.
// Assumes the bench changes the selects only while no word is in flight.
`timescale 1ns/1ps
module arp_host_model (
    input  logic        core_clk, // Core clock
    input  logic        serial,   // Serial mode selected
    input  logic [1:0]  div,      // Divide code to offer
    input  logic        ext,      // External clock wanted
    input  logic        rdc,      // Read timing select
    input  logic        go,       // Run the external clock
    input  logic [3:0]  half_per, // Clock half period in cycles
    input  logic [15:0] d_out,    // Device drive
    input  logic [15:0] d_oe_n,   // Device enable, low drives
    output logic [15:0] d_in      // Resolved pin levels
);
    logic [15:0] h_en;
    logic [15:0] h_val;
    logic [3:0]  cnt  = 4'h0;
    logic        sclk = 1'h0;
    logic        flip = 1'h0;

    // Clock stands low outside frames
    always @(posedge core_clk) begin
        flip <= ~flip;
        if (go && ext && serial) begin
            cnt <= (cnt == half_per - 4'h1) ? 4'h0 : cnt + 4'h1;
            if (cnt == half_per - 4'h1) sclk <= ~sclk;
        end else begin
            cnt  <= 4'h0;
            sclk <= 1'h0;
        end
    end

    // Divide lines driven only in read-after-convert with internal clock
    assign h_en  = {6'h00, serial & ext, 1'h0, serial, 2'h0, serial,
                    {2{serial & ~ext & ~rdc}}, 2'h0};
    assign h_val = {6'h00, sclk, 1'h0, rdc, 2'h0, ext, div, 2'h0};
    // Undriven lines toggle so a stale value cannot pass
    assign d_in  = (~d_oe_n & d_out) | (d_oe_n & h_en & h_val) | (d_oe_n & ~h_en & {16{flip}});
endmodule : arp_host_model

//--- dv/arp_port_tb.sv
// Self-checking bench for the result port in parallel and serial modes.
// Assumes the host model on the pins and a 125 MHz core clock.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module arp_port_tb;
    logic                  core_clk   = 1'h0;
    logic                  arst_n     = 1'h0;
    arp_pkg::arp_bus_req_t bus_req    = '0;
    logic [31:0]           bus_rdata;
    arp_pkg::arp_result_t  res_in     = '0;
    logic                  conv_start = 1'h0;
    logic                  half_sel   = 1'h0;
    logic                  code_sel   = 1'h1;
    logic                  port_sel   = 1'h0;
    logic [1:0]            div        = 2'h0;
    logic                  ext        = 1'h0;
    logic                  rdc        = 1'h0;
    logic                  go         = 1'h0;
    logic [3:0]            half_per   = 4'h3;
    logic [15:0]           d_in;
    logic [15:0]           d_out;
    logic [15:0]           d_oe_n;
    logic                  shift_active;
    int                    miscompares = 0;
    int                    n_checks    = 0;
    int                    cyc         = 0;

    always #4 core_clk = ~core_clk;

    arp_port DUT (.core_clk(core_clk), .arst_n(arst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .res_in(res_in), .conv_start(conv_start),
        .half_order_select(half_sel), .output_coding_select(code_sel),
        .port_type_select(port_sel), .d_in(d_in), .d_out(d_out), .d_oe_n(d_oe_n),
        .shift_active(shift_active));

    arp_host_model u_host (.core_clk(core_clk), .serial(port_sel), .div(div), .ext(ext),
        .rdc(rdc), .go(go), .half_per(half_per), .d_out(d_out), .d_oe_n(d_oe_n), .d_in(d_in));

    function automatic logic [15:0] fmt(input logic [15:0] raw, input logic bin);
        return bin ? raw : (raw ^ 16'h8000);
    endfunction : fmt

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge core_clk);
        bus_req.wr <= 1'h0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
        @(posedge core_clk);
        bus_req.rd <= 1'h0;
        @(negedge core_clk);
        `CHK(bus_rdata, e)
    endtask : bus_rd

    task automatic send(input logic [15:0] raw);
        @(posedge core_clk);
        res_in <= '{valid: 1'h1, data: raw};
        @(posedge core_clk);
        res_in.valid <= 1'h0;
    endtask : send

    task automatic t_regs();
        bus_rd(arp_pkg::ADDR_CTRL, 32'h1);
        bus_rd(8'h0C, 32'h0);
        bus_wr(8'h0C, 32'h0);
        bus_rd(arp_pkg::ADDR_CTRL, 32'h1);
        bus_wr(arp_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(d_oe_n, 16'hFFFF)
        `CHK(d_out, 16'h0000)
        bus_wr(arp_pkg::ADDR_CTRL, 32'h1);
    endtask : t_regs

    task automatic t_parallel();
        logic [15:0] a;
        logic [15:0] b;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            half_sel <= i[1];
            code_sel <= i[0];
            repeat (2) @(posedge core_clk);
            res_in <= '{valid: 1'h1, data: 16'h12F4};
            @(posedge core_clk);
            res_in.data <= 16'h8A01;
            @(posedge core_clk);
            res_in.valid <= 1'h0;
            a = fmt(16'h12F4, i[0]);
            b = fmt(16'h8A01, i[0]);
            @(negedge core_clk);
            `CHK(d_out, i[1] ? {a[7:0], a[15:8]} : a)
            `CHK(d_oe_n, 16'h0000)
            @(negedge core_clk);
            `CHK(d_out, i[1] ? {b[7:0], b[15:8]} : b)
            bus_rd(arp_pkg::ADDR_RESULT, {16'h0, b});
        end
    endtask : t_parallel

    task automatic t_ser_int(input logic [1:0] c, input logic r, input int per);
        @(posedge core_clk);
        {port_sel, ext, rdc, div, code_sel, half_sel} <= {2'h2, r, c, 2'h2};
        repeat (3) @(posedge core_clk);
        bus_rd(arp_pkg::ADDR_STATUS, {27'h0, r ? 2'h0 : c, r, 2'h1});
        send(16'hB35C);
        if (r) begin
            repeat (3) @(negedge core_clk);
            `CHK(shift_active, 1'h0)
            @(posedge core_clk);
            conv_start <= 1'h1;
            @(posedge core_clk);
            conv_start <= 1'h0;
        end
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK(shift_active, 1'h1)
        `CHK(d_oe_n[3:0], 4'hF)
        `CHK(d_oe_n[9:8], 2'h0)
        for (int k = 0; k < 16; k++) begin
            `CHK(d_out[9], 1'h0)
            `CHK(d_out[8], 16'hB35C >> (15 - k) & 16'h1)
            repeat (per / 2) @(negedge core_clk);
            `CHK(d_out[9], 1'h1)
            repeat (per - per / 2) @(negedge core_clk);
        end
        repeat (2) @(negedge core_clk);
        `CHK({shift_active, d_out[9]}, 2'h0)
    endtask : t_ser_int

    task automatic t_ser_ext(input logic [15:0] raw, input logic bin, input logic [3:0] hp);
        logic [15:0] w;
        int          k;
        int          n;
        logic        prev;
        w = fmt(raw, bin);
        @(posedge core_clk);
        {port_sel, ext, rdc, div, code_sel, half_per} <= {3'h6, 2'h3, bin, hp};
        repeat (3) @(posedge core_clk);
        bus_rd(arp_pkg::ADDR_STATUS, 32'h3);
        send(raw);
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK({d_oe_n[9], d_oe_n[3:0]}, 5'h1F)
        @(posedge core_clk);
        go <= 1'h1;
        k = 0;
        n = 0;
        prev = 1'h0;
        while (k < 16 && n < 2000) begin
            @(negedge core_clk);
            n++;
            if (d_in[9] && !prev) begin
                `CHK(d_out[8], w[15 - k])
                k++;
            end
            prev = d_in[9];
        end
        @(posedge core_clk);
        go <= 1'h0;
        `CHK(k, 16)
        repeat (4) @(negedge core_clk);
        `CHK(shift_active, 1'h0)
    endtask : t_ser_ext

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(negedge core_clk);
        `CHK({d_oe_n, bus_rdata, shift_active}, {16'hFFFF, 33'h0})
        repeat (3) @(posedge core_clk);
        arst_n <= 1'h1;
        t_regs();
        t_parallel();
        t_ser_int(2'h0, 1'h0, 4);
        t_ser_int(2'h1, 1'h0, 7);
        t_ser_int(2'h2, 1'h0, 13);
        t_ser_int(2'h3, 1'h0, 25);
        t_ser_int(2'h3, 1'h1, 4);
        t_ser_ext(16'h4E21, 1'h0, 4'h3);
        t_ser_ext(16'hC0F5, 1'h1, 4'h7);
        give_verdict();
    end
endmodule : arp_port_tb
